// >>> pkg/cap_seq_defines.svh
/*
 Offsets, field reset values and timing figures for the conversion sequencer.
 Assumes inclusion by bare name from files that need these constants.
*/
`ifndef CAP_SEQ_DEFINES_SVH
`define CAP_SEQ_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CTRL_OFS        12'h000
`define CALCTL_OFS      12'h002
`define BTNA_OFS        12'h009
`define BTNB_OFS        12'h00A
`define RAW_OFS         12'h00B
`define CFG_BASE        12'h080
`define RES_BASE        12'h0E0

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define CTRL_RST        16'h00B0
`define CALCTL_RST      16'h0000
`define PWR_FULL        2'h0
`define PWR_LOW         2'h2
`define OSR_128         2'h1
`define NUM_STAGES      12
`define LAST_MAX        4'hB

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ         25
`define STAGE128_US     1536
`define STAGE256_US     3072
`define SLEEP_STEP_US   200000
`define TOUCH_PER_US    36000
`define FP_HOLD_MUL     16
`define LP_HOLD_MUL     4

`endif

// >>> pkg/cap_seq_pkg.sv
/*
 Types shared by the conversion sequencer and its bench.
 Assumes cap_seq_defines.svh holds the numeric constants.
*/
package cap_seq_pkg;

    // ----------------------------------------
    // Register layouts
    // ----------------------------------------
    typedef struct packed {
        logic [5:0] rsvd;
        logic [1:0] osr_sel;
        logic [3:0] last_stage_index;
        logic [1:0] sleep_interval_sel;
        logic [1:0] power_state_sel;
    } ctrl_t;

    typedef struct packed {
        logic [3:0] rsvd;
        logic [3:0] lowpwr_caldis_count;
        logic [3:0] fullpwr_caldis_count;
        logic [3:0] skip;
    } calctl_t;

    // Stage request toward the converter front end
    typedef struct packed {
        logic [3:0]  stage;
        logic [15:0] cfg;
    } stage_req_t;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b001,
        S_CONV  = 3'b010,
        S_SLEEP = 3'b100
    } seq_state_t;

endpackage

// >>> verilog/cap_conversion_sequencer.sv
/*
 Stage sequencer, register file and calibration hold-off for a capacitance
 to digital converter. Assumes the front end converts whatever stage it is
 told and that its result and hit levels are valid at each stage end.
*/
// Contract
// - At most twelve stages run in one sequence, each may use another input.
// - Sequences start at the first stage and step up to last_stage_index.
// - Stage time is 1.536 ms at ratio 128, 3.072 ms at 256.
// - Every stage has its own configuration register.
// - A differential pair reports one button at most, none when both pressed.
// - sleep_interval_sel selects 200, 400, 600 or 800 ms between sequences.
// - Low power wakes itself; period is sequence time plus sleep interval.
// - Raw 16-bit converter output is readable at offset 0x00B.
// - Per-stage results are readable in the third bank.
// - Proximity disables ambient calibration at once.
// - After proximity, calibration returns after hold-off if untouched.
// - Full-power hold-off is fullpwr_caldis_count times 16 sequences.
// - Low-power hold-off is lowpwr_caldis_count times 4 sequences.
// - power_state_sel: 00 full, 10 low, 01 or 11 shutdown; resets to 00.
// - Oversample code 00 gives ratio 256, code 01 ratio 128.
// - Touched in low power, a sequence starts every 36 ms.
`timescale 1ns/10ps
`include "cap_seq_defines.svh"

module cap_conversion_sequencer #(
    parameter int STAGE128_CYC = `STAGE128_US * `CLK_MHZ,
    parameter int STAGE256_CYC = `STAGE256_US * `CLK_MHZ,
    parameter int SLEEP_STEP_CYC = `SLEEP_STEP_US * `CLK_MHZ,
    parameter int TOUCH_PER_CYC = `TOUCH_PER_US * `CLK_MHZ
) (
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     RST,
    // Register port
    input  wire logic [11:0]              REG_ADDR,
    input  wire logic                     REG_WR,
    input  wire logic [15:0]              REG_WDATA,
    input  wire logic                     REG_RD,
    output logic      [15:0]              REG_RDATA,
    // Converter front end
    input  wire logic [15:0]              CONV_RESULT,
    input  wire logic                     HIT_POS,
    input  wire logic                     HIT_NEG,
    output cap_seq_pkg::stage_req_t       STAGE_REQ,
    output logic                          STAGE_START,
    output logic                          SEQ_DONE,
    // Sensor status and calibration
    input  wire logic                     PROX,
    input  wire logic                     TOUCH,
    output logic                          CAL_EN
);
    import cap_seq_pkg::*;

    // ----------------------------------------
    // Register group
    // ----------------------------------------
    ctrl_t        ctrl_r, ctrl_nxt;
    calctl_t      calctl_r, calctl_nxt;
    logic [15:0]  cfg_r [`NUM_STAGES], cfg_nxt [`NUM_STAGES];
    logic [15:0]  rdata_r, rdata_nxt;
    logic [15:0]  res_r [`NUM_STAGES], res_nxt [`NUM_STAGES];
    logic [15:0]  raw_r, raw_nxt;
    logic [11:0]  btna_r, btna_nxt;
    logic [11:0]  btnb_r, btnb_nxt;
    always_comb begin
        ctrl_nxt   = ctrl_r;
        calctl_nxt = calctl_r;
        cfg_nxt    = cfg_r;
        rdata_nxt  = rdata_r;
        if (REG_WR) begin
            if (REG_ADDR == `CTRL_OFS) ctrl_nxt = ctrl_t'(REG_WDATA);
            if (REG_ADDR == `CALCTL_OFS) calctl_nxt = calctl_t'(REG_WDATA);
            for (int i = 0; i < `NUM_STAGES; i++) begin
                if (REG_ADDR == `CFG_BASE + 12'(i)) cfg_nxt[i] = REG_WDATA;
            end
        end
        if (REG_RD) begin
            rdata_nxt = 16'h0000;
            if (REG_ADDR == `CTRL_OFS) rdata_nxt = 16'(ctrl_r);
            if (REG_ADDR == `CALCTL_OFS) rdata_nxt = 16'(calctl_r);
            if (REG_ADDR == `BTNA_OFS) rdata_nxt = {4'h0, btna_r};
            if (REG_ADDR == `BTNB_OFS) rdata_nxt = {4'h0, btnb_r};
            if (REG_ADDR == `RAW_OFS) rdata_nxt = raw_r;
            for (int i = 0; i < `NUM_STAGES; i++) begin
                if (REG_ADDR == `CFG_BASE + 12'(i)) rdata_nxt = cfg_r[i];
                if (REG_ADDR == `RES_BASE + 12'(i)) rdata_nxt = res_r[i];
            end
        end
    end
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl_r   <= ctrl_t'(`CTRL_RST);
            calctl_r <= calctl_t'(`CALCTL_RST);
            rdata_r  <= 16'h0000;
            cfg_r    <= '{default: 16'h0000};
        end else begin
            ctrl_r   <= ctrl_nxt;
            calctl_r <= calctl_nxt;
            rdata_r  <= rdata_nxt;
            cfg_r    <= cfg_nxt;
        end
    end
    assign REG_RDATA = rdata_r;

    // ----------------------------------------
    // Sequencer group
    // ----------------------------------------
    seq_state_t   st_r, st_nxt;
    logic [3:0]   stage_r, stage_nxt;
    logic [31:0]  tmr_r, tmr_nxt;
    logic [31:0]  pcnt_r, pcnt_nxt;
    logic         start_r, start_nxt;
    logic         seqend_r, seqend_nxt;
    stage_req_t   req_r, req_nxt;
    logic [3:0]   last_eff;
    logic [31:0]  stage_cyc;
    logic [31:0]  sleep_cyc;
    logic         shutdown;
    logic         stage_end;
    // Out-of-range counts clamp so a bad write cannot run past stage eleven
    assign last_eff  = (ctrl_r.last_stage_index > `LAST_MAX) ? `LAST_MAX
                                                             : ctrl_r.last_stage_index;
    assign stage_cyc = (ctrl_r.osr_sel == `OSR_128) ? 32'(STAGE128_CYC)
                                                    : 32'(STAGE256_CYC);
    assign sleep_cyc = (32'(ctrl_r.sleep_interval_sel) + 32'h1) * 32'(SLEEP_STEP_CYC);
    assign shutdown  = ctrl_r.power_state_sel[0];
    // At or past the end, so a shorter ratio written mid-stage cannot hang it
    assign stage_end = (st_r == S_CONV) && (tmr_r >= stage_cyc - 32'h1);
    always_comb begin
        st_nxt     = st_r;
        stage_nxt  = stage_r;
        tmr_nxt    = tmr_r + 32'h1;
        pcnt_nxt   = pcnt_r + 32'h1;
        start_nxt  = 1'b0;
        seqend_nxt = 1'b0;
        raw_nxt    = raw_r;
        res_nxt    = res_r;
        btna_nxt   = btna_r;
        btnb_nxt   = btnb_r;
        unique case (st_r)
            S_IDLE: begin
                tmr_nxt = 32'h0;
                if (!shutdown) begin
                    st_nxt    = S_CONV;
                    stage_nxt = 4'h0;
                    pcnt_nxt  = 32'h0;
                    start_nxt = 1'b1;
                end
            end
            S_CONV: begin
                if (shutdown) begin
                    st_nxt = S_IDLE;
                end else if (stage_end) begin
                    raw_nxt          = CONV_RESULT;
                    res_nxt[stage_r] = CONV_RESULT;
                    // Pair reading: one side only, both pressed cancels
                    btna_nxt[stage_r] = HIT_POS & ~(cfg_r[stage_r][0] & HIT_NEG);
                    btnb_nxt[stage_r] = cfg_r[stage_r][0] & HIT_NEG & ~HIT_POS;
                    tmr_nxt           = 32'h0;
                    if (stage_r >= last_eff) begin
                        seqend_nxt = 1'b1;
                        if (ctrl_r.power_state_sel == `PWR_LOW) begin
                            st_nxt = S_SLEEP;
                        end else begin
                            stage_nxt = 4'h0;
                            pcnt_nxt  = 32'h0;
                            start_nxt = 1'b1;
                        end
                    end else begin
                        stage_nxt = stage_r + 4'h1;
                        start_nxt = 1'b1;
                    end
                end
            end
            S_SLEEP: begin
                if (shutdown) begin
                    st_nxt = S_IDLE;
                end else if (tmr_r >= sleep_cyc - 32'h1
                             || (TOUCH && pcnt_r >= 32'(TOUCH_PER_CYC) - 32'h1)
                             || ctrl_r.power_state_sel == `PWR_FULL) begin
                    st_nxt    = S_CONV;
                    stage_nxt = 4'h0;
                    tmr_nxt   = 32'h0;
                    pcnt_nxt  = 32'h0;
                    start_nxt = 1'b1;
                end
            end
        endcase
        req_nxt = '{stage: stage_nxt, cfg: cfg_r[stage_nxt]};
    end
    always_ff @(posedge CLK) begin
        if (RST) begin
            st_r     <= S_IDLE;
            stage_r  <= 4'h0;
            tmr_r    <= 32'h0;
            pcnt_r   <= 32'h0;
            start_r  <= 1'b0;
            seqend_r <= 1'b0;
            req_r    <= '0;
            raw_r    <= 16'h0000;
            btna_r   <= 12'h000;
            btnb_r   <= 12'h000;
            res_r    <= '{default: 16'h0000};
        end else begin
            st_r     <= st_nxt;
            stage_r  <= stage_nxt;
            tmr_r    <= tmr_nxt;
            pcnt_r   <= pcnt_nxt;
            start_r  <= start_nxt;
            seqend_r <= seqend_nxt;
            req_r    <= req_nxt;
            raw_r    <= raw_nxt;
            res_r    <= res_nxt;
            btna_r   <= btna_nxt;
            btnb_r   <= btnb_nxt;
        end
    end
    assign STAGE_REQ   = req_r;
    assign STAGE_START = start_r;
    assign SEQ_DONE    = seqend_r;

    // ----------------------------------------
    // Calibration hold-off group
    // ----------------------------------------
    logic [7:0]   hold_r, hold_nxt;
    logic         calen_r, calen_nxt;

    always_comb begin
        hold_nxt  = hold_r;
        calen_nxt = calen_r;
        if (PROX) begin
            calen_nxt = 1'b0;
            // Reloaded while proximity lasts, so counting starts when it ends
            hold_nxt = (ctrl_r.power_state_sel == `PWR_LOW)
                       ? 8'(calctl_r.lowpwr_caldis_count * `LP_HOLD_MUL)
                       : 8'(calctl_r.fullpwr_caldis_count * `FP_HOLD_MUL);
        end else if (!calen_r) begin
            if (hold_r != 8'h00) begin
                if (seqend_r) hold_nxt = hold_r - 8'h01;
            end else if (!TOUCH) begin
                calen_nxt = 1'b1;
            end
        end
    end
    always_ff @(posedge CLK) begin
        if (RST) begin
            hold_r  <= 8'h00;
            calen_r <= 1'b1;
        end else begin
            hold_r  <= hold_nxt;
            calen_r <= calen_nxt;
        end
    end
    assign CAL_EN = calen_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    stage_bound_a: assert property (start_r && $stable(ctrl_r)
        |-> stage_r <= last_eff) else $error("stage beyond last stage");
    stage_step_a: assert property (stage_end && stage_r < last_eff && !shutdown
        |=> stage_r == $past(stage_r) + 4'h1 && start_r) else $error("stage did not step");
    seq_wrap_a: assert property (stage_end && stage_r >= last_eff
        && ctrl_r.power_state_sel == `PWR_FULL |=> st_r == S_CONV && stage_r == 4'h0
        && start_r && SEQ_DONE) else $error("no wrap to first stage");
    stage_len_a: assert property (st_r == S_CONV && $stable(ctrl_r.osr_sel)
        |-> tmr_r < stage_cyc) else $error("stage ran long");
    osr_sel_a: assert property (ctrl_r.osr_sel == 2'h0 |-> stage_cyc == 32'(STAGE256_CYC))
        else $error("ratio 256 timing wrong");
    sleep_len_a: assert property (st_r == S_SLEEP && $stable(ctrl_r.sleep_interval_sel)
        |-> tmr_r < sleep_cyc) else $error("sleep ran long");
    touch_wake_a: assert property (st_r == S_SLEEP && TOUCH && !shutdown
        && pcnt_r >= 32'(TOUCH_PER_CYC) - 32'h1 |=> st_r == S_CONV && stage_r == 4'h0)
        else $error("touched wake missed");
    low_sleep_a: assert property (stage_end && stage_r >= last_eff && !shutdown
        && ctrl_r.power_state_sel == `PWR_LOW |=> st_r == S_SLEEP) else $error("no sleep");
    shut_idle_a: assert property (shutdown && st_r != S_IDLE |=> st_r == S_IDLE)
        else $error("shutdown ignored");
    prox_off_a: assert property (PROX |=> !CAL_EN) else $error("cal left on");
    cal_back_a: assert property ($rose(CAL_EN) |-> $past(hold_r) == 8'h00
        && !$past(PROX) && !$past(TOUCH)) else $error("cal back too early");
    fp_hold_a: assert property (PROX && ctrl_r.power_state_sel != `PWR_LOW
        |=> hold_r == 8'($past(calctl_r.fullpwr_caldis_count) * 16))
        else $error("full power hold wrong");
    lp_hold_a: assert property (PROX && ctrl_r.power_state_sel == `PWR_LOW
        |=> hold_r == 8'($past(calctl_r.lowpwr_caldis_count) * 4))
        else $error("low power hold wrong");
    pair_one_a: assert property (!(|(btna_r & btnb_r))) else $error("both buttons");
    raw_cap_a: assert property (stage_end && !shutdown |=> raw_r == $past(CONV_RESULT))
        else $error("raw result not captured");
endmodule

// >>> testbench/cap_frontend_model.sv
/*
 Converter front end model for the sequencer bench.
 Assumes the bench sets the comparator levels that each test wants.
*/
`timescale 1ns/10ps

module cap_frontend_model (
    // Sequencer side
    input  wire logic                    clk,
    input  wire cap_seq_pkg::stage_req_t req,
    input  wire logic                    start,
    // Bench controls
    input  wire logic                    pos_lvl,
    input  wire logic                    neg_lvl,
    // Converter outputs
    output logic [15:0]                  result,
    output logic                         hit_pos,
    output logic                         hit_neg
);
    import cap_seq_pkg::*;

    logic [3:0] age = 4'hF;

    // Result settles a few cycles into a stage, so an early sample sees junk
    always @(posedge clk) begin
        age <= start ? 4'h0 : ((age == 4'hF) ? age : age + 4'h1);
    end

    assign result  = (age > 4'h2) ? {12'hA50, req.stage} : ~{12'hA50, req.stage};
    assign hit_pos = pos_lvl;
    assign hit_neg = neg_lvl;
endmodule

// >>> testbench/tb_cap_conversion_sequencer.sv
/*
 Self-checking bench for the conversion sequencer.
 Assumes shortened stage, sleep and touch counts as set below.
*/
`timescale 1ns/10ps
`include "cap_seq_defines.svh"

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (got), (exp)); end end

module tb_cap_conversion_sequencer;
    import cap_seq_pkg::*;

    localparam int N128 = 20;
    localparam int N256 = 40;
    localparam int STEP = 200;
    localparam int TPER = 100;

    logic        clk     = 1'b0;
    logic        rst     = 1'b1;
    logic [11:0] addr    = 12'h000;
    logic        wr      = 1'b0;
    logic [15:0] wdata   = 16'h0000;
    logic        rd      = 1'b0;
    logic [15:0] rdata;
    logic [15:0] result;
    logic        hp;
    logic        hn;
    stage_req_t  req;
    logic        start;
    logic        done;
    logic        prox    = 1'b0;
    logic        touch   = 1'b0;
    logic        cal_en;
    logic        pos_lvl = 1'b0;
    logic        neg_lvl = 1'b0;
    int          error_cnt = 0;
    int          compares  = 0;

    cap_conversion_sequencer #(.STAGE128_CYC(N128), .STAGE256_CYC(N256),
        .SLEEP_STEP_CYC(STEP), .TOUCH_PER_CYC(TPER)) uut (
        .CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
        .REG_RD(rd), .REG_RDATA(rdata), .CONV_RESULT(result), .HIT_POS(hp),
        .HIT_NEG(hn), .STAGE_REQ(req), .STAGE_START(start), .SEQ_DONE(done),
        .PROX(prox), .TOUCH(touch), .CAL_EN(cal_en));

    cap_frontend_model fe (.clk(clk), .req(req), .start(start), .pos_lvl(pos_lvl),
        .neg_lvl(neg_lvl), .result(result), .hit_pos(hp), .hit_neg(hn));

    always #20 clk = ~clk;

    // ----------------------------------------
    // Access and timing tasks
    // ----------------------------------------
    task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [11:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Bounded so a stuck sequencer shows as a bad count, not a hang
    task automatic next_start(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (start !== 1'b1 && n < 5000);
    endtask

    task automatic seq_end;
        int n;
        do begin
            next_start(n);
        end while (done !== 1'b1 && n < 5000);
    endtask

    // First two starts after a mode change may be irregular
    task automatic period(output int n);
        int d;
        next_start(d);
        next_start(d);
        next_start(n);
    endtask

    task automatic prox_hold(output int n);
        int c;
        @(posedge clk);
        prox <= 1'b1;
        @(posedge clk);
        #1;
        `CHK(cal_en, 1'b0)
        repeat (3) @(posedge clk);
        prox <= 1'b0;
        n = 0;
        c = 0;
        #1;
        while (cal_en !== 1'b1 && c < 6000) begin
            if (done === 1'b1) n++;
            @(posedge clk);
            #1;
            c++;
        end
    endtask

    function automatic logic [15:0] ctl(input logic [1:0] o, input logic [3:0] l,
                                        input logic [1:0] s, input logic [1:0] p);
        return {6'h00, o, l, s, p};
    endfunction

    task automatic end_of_test;
        $display("Compares %0d, errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        int          n;
        int          i;
        int          k;
        logic [15:0] v;
        logic [2:0]  e;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`CTRL_OFS, v);
        `CHK(v, `CTRL_RST)
        `CHK(cal_en, 1'b1)
        rd_reg(12'h7FF, v);
        `CHK(v, 16'h0000)
        for (k = 0; k < 4; k++) begin
            wr_reg(`CTRL_OFS, ctl(k[1:0], 4'h0, 2'h0, `PWR_FULL));
            period(n);
            `CHK(n, (k == 1) ? N128 : N256)
        end
        wr_reg(`CTRL_OFS, ctl(`OSR_128, 4'h1, 2'h0, `PWR_FULL));
        seq_end;
        next_start(n);
        `CHK(n, N128)
        `CHK(req.stage, 4'h1)
        next_start(n);
        `CHK(n, N128)
        `CHK(done, 1'b1)
        // Top bits stand for the calibration enables of the stages in use
        for (i = 0; i < 12; i++) wr_reg(`CFG_BASE + i[11:0], 16'hC000 | 16'(i << 8));
        wr_reg(`CTRL_OFS, ctl(`OSR_128, 4'hF, 2'h0, `PWR_FULL));
        seq_end;
        `CHK(req.cfg, 16'hC000)
        i = 0;
        do begin
            next_start(n);
            i++;
            if (done !== 1'b1) begin
                `CHK(req.stage, i[3:0])
                `CHK(req.cfg, 16'hC000 | (i << 8))
            end
        end while (done !== 1'b1 && i < 20);
        `CHK(i, 12)
        rd_reg(`RAW_OFS, v);
        `CHK(v, 16'hA50B)
        for (i = 0; i < 12; i++) begin
            rd_reg(`RES_BASE + i[11:0], v);
            `CHK(v, 16'hA500 | i)
        end
        // Eight-way switch layout: two pair stages and one activity stage
        wr_reg(`CFG_BASE, 16'h0001);
        wr_reg(`CFG_BASE + 12'h001, 16'h0001);
        wr_reg(`CTRL_OFS, ctl(`OSR_128, 4'h2, 2'h0, `PWR_FULL));
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            pos_lvl <= k[0];
            neg_lvl <= k[1];
            seq_end;
            seq_end;
            rd_reg(`BTNA_OFS, v);
            e = {k[0], k[0] & ~k[1], k[0] & ~k[1]};
            `CHK(v[2:0], e)
            rd_reg(`BTNB_OFS, v);
            e = {1'b0, k[1] & ~k[0], k[1] & ~k[0]};
            `CHK(v[2:0], e)
        end
        for (k = 1; k < 4; k += 2) begin
            wr_reg(`CTRL_OFS, ctl(`OSR_128, 4'h0, 2'h0, k[1:0]));
            repeat (3) @(posedge clk);
            n = 0;
            repeat (300) begin
                @(posedge clk);
                #1;
                if (start === 1'b1) n++;
            end
            `CHK(n, 0)
        end
        for (k = 0; k < 4; k++) begin
            wr_reg(`CTRL_OFS, ctl(`OSR_128, 4'h0, k[1:0], `PWR_LOW));
            period(n);
            `CHK(n >= N128 + (k + 1) * STEP && n <= N128 + (k + 1) * STEP + 3, 1'b1)
        end
        @(posedge clk);
        touch <= 1'b1;
        period(n);
        `CHK(n >= TPER && n <= TPER + 2, 1'b1)
        @(posedge clk);
        touch <= 1'b0;
        wr_reg(`CALCTL_OFS, 16'h0110);
        for (k = 0; k < 2; k++) begin
            wr_reg(`CTRL_OFS, ctl(`OSR_128, 4'h0, 2'h0, (k == 1) ? `PWR_LOW : `PWR_FULL));
            prox_hold(n);
            `CHK(n, (k == 1) ? 4 : 16)
        end
        wr_reg(`CALCTL_OFS, 16'h0000);
        @(posedge clk);
        touch <= 1'b1;
        prox_hold(n);
        `CHK(cal_en, 1'b0)
        @(posedge clk);
        touch <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        `CHK(cal_en, 1'b1)
        end_of_test;
    end

    // Whole run needs about 15000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        end_of_test;
    end
endmodule
